// ===== hw/gpsl_pkg.sv
`default_nettype none

package gpsl_pkg;

  // ******************************************************************
  // sizes
  // ******************************************************************
  localparam int PIN_COUNT = 32;
  localparam int PIN_IDX_W = 5;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int STRB_W = 4;
  localparam int IRQ_W = 1;

  // ******************************************************************
  // register map (byte addresses)
  // ******************************************************************
  localparam logic [ADDR_W-1:0] OFS_OUT_VALUE = 12'h504;
  localparam logic [ADDR_W-1:0] OFS_PIN_LEVEL = 12'h510;
  localparam logic [ADDR_W-1:0] OFS_DIRECTION = 12'h514;
  localparam logic [ADDR_W-1:0] OFS_DIR_SET = 12'h518;
  localparam logic [ADDR_W-1:0] OFS_DIR_CLR = 12'h51C;
  localparam logic [ADDR_W-1:0] OFS_SENSE_HIT = 12'h520;
  localparam logic [ADDR_W-1:0] OFS_DET_SRC = 12'h524;
  localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS = 12'h600;
  localparam logic [ADDR_W-1:0] OFS_IRQ_CLEAR = 12'h604;
  localparam logic [ADDR_W-1:0] OFS_IRQ_ENABLE = 12'h608;
  localparam logic [ADDR_W-1:0] OFS_PIN_SETUP = 12'h700;
  // pin setup words span 32 words, so address bits 11:7 pick the block
  localparam int SETUP_SPAN_LSB = 7;
  localparam int SETUP_IDX_LSB = 2;

  // ******************************************************************
  // pin setup word layout and reset
  // ******************************************************************
  localparam int CFG_DIR_BIT = 0;
  localparam int CFG_INBUF_BIT = 1;
  localparam int CFG_PULL_LSB = 2;
  localparam int CFG_DRIVE_LSB = 8;
  localparam int CFG_SENSE_LSB = 16;
  localparam logic [DATA_W-1:0] CFG_RESET = 32'h00000002;
  localparam logic [DATA_W-1:0] REG_RESET = 32'h00000000;
  localparam int DET_SRC_BIT = 0;
  localparam int IRQ_DETECT_BIT = 0;

  // ******************************************************************
  // encodings
  // ******************************************************************
  typedef enum logic [2:0] {
    DRV_STD_STD = 3'h0,
    DRV_HI0_STD = 3'h1,
    DRV_STD_HI1 = 3'h2,
    DRV_HI_HI = 3'h3,
    DRV_OPEN0_STD = 3'h4,
    DRV_OPEN0_HI = 3'h5,
    DRV_STD_OPEN1 = 3'h6,
    DRV_HI_OPEN1 = 3'h7
  } gpsl_drive_t;

  typedef enum logic [1:0] {
    SNS_OFF = 2'h0,
    SNS_RSVD = 2'h1,
    SNS_HIGH = 2'h2,
    SNS_LOW = 2'h3
  } gpsl_sense_t;

  localparam logic [1:0] PULL_NONE = 2'h0;
  localparam logic [1:0] PULL_DOWN = 2'h1;
  localparam logic [1:0] PULL_UP = 2'h3;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

`default_nettype wire

// ===== hw/gpsl_pin_cell.sv
`timescale 1ns/1ps
`default_nettype none

module gpsl_pin_cell
(
  input wire logic dir,
  input wire logic out_value,
  input wire logic in_disc,
  input wire logic level,
  input wire gpsl_pkg::gpsl_drive_t drive,
  input wire gpsl_pkg::gpsl_sense_t sense,
  output logic pad_out,
  output logic pad_oe,
  output logic hi_drive,
  output logic sense_hit
);
  import gpsl_pkg::*;

  logic low_open;
  logic high_open;
  logic in_seen;

  // ******************************************************************
  // driver
  // ******************************************************************
  always_comb
  begin
    low_open = 1'b0;
    high_open = 1'b0;
    hi_drive = 1'b0;
    unique case (drive)
      DRV_STD_STD: hi_drive = 1'b0; // [RQ7]
      DRV_HI0_STD: hi_drive = ~out_value; // [RQ7]
      DRV_STD_HI1: hi_drive = out_value; // [RQ7]
      DRV_HI_HI: hi_drive = 1'b1; // [RQ7]
      DRV_OPEN0_STD:
      begin
        low_open = 1'b1; // [RQ8]
      end
      DRV_OPEN0_HI:
      begin
        low_open = 1'b1; // [RQ8]
        hi_drive = out_value;
      end
      DRV_STD_OPEN1:
      begin
        high_open = 1'b1; // [RQ9]
      end
      DRV_HI_OPEN1:
      begin
        high_open = 1'b1; // [RQ9]
        hi_drive = ~out_value;
      end
    endcase
  end

  // an open level releases the pad so a wired-or/and bus can settle
  assign pad_out = out_value;
  assign pad_oe = dir & ~(low_open & ~out_value)
    & ~(high_open & out_value); // [RQ5] [RQ8] [RQ9]

  // ******************************************************************
  // sense
  // ******************************************************************
  // a disconnected buffer hides the pin from sensing altogether
  assign in_seen = ~in_disc; // [RQ6]

  always_comb
  begin
    case (sense)
      SNS_HIGH: sense_hit = in_seen & level; // [RQ10]
      SNS_LOW: sense_hit = in_seen & ~level; // [RQ10]
      default: sense_hit = 1'b0; // [RQ10]
    endcase
  end

endmodule

`default_nettype wire

// ===== hw/gpsl_port.sv
// Behaviour
// (RQ1) sense-hit record at 0x520 sets on pin sense, clears by writing one.
// (RQ2) detect source 0: detect output is the OR of live pin senses.
// (RQ3) detect source 1 at 0x524: detect output follows the sense-hit record.
// (RQ4) 32 pin setup words at 0x700 plus 4n, reset value 0x00000002.
// (RQ5) setup direction bit is the port direction bit; 1 means output.
// (RQ6) input buffer bit 0 connects, 1 disconnects; disconnected after reset.
// (RQ7) drive codes 0..3 choose standard or high strength per level.
// (RQ8) drive codes 4,5 release low level; high standard or strong.
// (RQ9) drive codes 6,7 release high level; low standard or strong.
// (RQ10) sense code 0 off, 2 senses high, 3 senses low.
// (RQ11) writing one to direction-set makes a pin output; zero does nothing.
// (RQ12) pull code 0 none, 1 down, 3 up, 2 reserved as none.
// (RQ13) setup word fields at bits 0, 1, 3:2, 10:8, 17:16; rest zero.
//
// Decided for this implementation: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module gpsl_port
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [gpsl_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [gpsl_pkg::DATA_W-1:0] s_axi_wdata,
  input wire logic [gpsl_pkg::STRB_W-1:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [gpsl_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [gpsl_pkg::DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [gpsl_pkg::PIN_COUNT-1:0] pin_in,
  output logic [gpsl_pkg::PIN_COUNT-1:0] pin_out,
  output logic [gpsl_pkg::PIN_COUNT-1:0] pin_oe,
  output logic [gpsl_pkg::PIN_COUNT-1:0] pin_hi_drive,
  output logic [gpsl_pkg::PIN_COUNT-1:0] pin_in_en,
  output logic [gpsl_pkg::PIN_COUNT-1:0] pin_pull_up,
  output logic [gpsl_pkg::PIN_COUNT-1:0] pin_pull_dn,
  output logic port_detect,
  output logic irq
);
  import gpsl_pkg::*;

  localparam int NP = PIN_COUNT;
  localparam int BYTE_W = DATA_W / STRB_W;

  typedef struct packed {
    // pin side: synchroniser, configuration and sense record
    logic [NP-1:0] sync1;
    logic [NP-1:0] sync2;
    logic [NP-1:0] sync3;
    logic [NP-1:0] level;
    logic [NP-1:0] out_value;
    logic [NP-1:0] dir;
    logic [NP-1:0] in_disc;
    logic [NP-1:0] hit;
    logic [NP-1:0][1:0] pull;
    logic [NP-1:0][2:0] drive;
    logic [NP-1:0][1:0] sense;
    logic det_src;
    logic det_prev;
    logic [IRQ_W-1:0] irq_stat;
    logic [IRQ_W-1:0] irq_en;
    // bus side: captured write halves and pending answers
    logic aw_got;
    logic w_got;
    logic [ADDR_W-1:0] awaddr;
    logic [DATA_W-1:0] wdata;
    logic [STRB_W-1:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [DATA_W-1:0] rdata;
  } gpsl_state_t;

  gpsl_state_t q;
  gpsl_state_t d;

  logic [NP-1:0] sense_vec;
  logic live_detect;
  logic latched_port_sense;
  logic detect;
  logic detect_rise;

  // ******************************************************************
  // helpers
  // ******************************************************************
  function automatic logic [DATA_W-1:0] setup_word(input gpsl_state_t s,
    input logic [PIN_IDX_W-1:0] n);
    logic [DATA_W-1:0] w;
    w = REG_RESET;
    w[CFG_DIR_BIT] = s.dir[n]; // [RQ5] [RQ13]
    w[CFG_INBUF_BIT] = s.in_disc[n]; // [RQ13]
    w[CFG_PULL_LSB +: 2] = s.pull[n]; // [RQ13]
    w[CFG_DRIVE_LSB +: 3] = s.drive[n]; // [RQ13]
    w[CFG_SENSE_LSB +: 2] = s.sense[n]; // [RQ13]
    return w;
  endfunction

  function automatic logic is_setup(input logic [ADDR_W-1:0] a);
    return a[ADDR_W-1:SETUP_SPAN_LSB]
      == OFS_PIN_SETUP[ADDR_W-1:SETUP_SPAN_LSB];
  endfunction

  // each strobe bit opens one byte lane; closed lanes keep their old value
  function automatic logic [DATA_W-1:0] byte_mask(
    input logic [STRB_W-1:0] strb);
    logic [DATA_W-1:0] msk;
    msk = REG_RESET;
    for (int b = 0; b < STRB_W; b++)
    begin
      msk[b*BYTE_W +: BYTE_W] = {BYTE_W{strb[b]}};
    end
    return msk;
  endfunction

  // ******************************************************************
  // per-pin cells
  // ******************************************************************
  // pin_out always carries the register; pin_oe decides if it reaches the pad
  genvar gi;
  generate
    for (gi = 0; gi < NP; gi++)
    begin : g_pin
      gpsl_pin_cell u_cell
      (
        .dir(q.dir[gi]),
        .out_value(q.out_value[gi]),
        .in_disc(q.in_disc[gi]),
        .level(q.level[gi]),
        .drive(gpsl_drive_t'(q.drive[gi])),
        .sense(gpsl_sense_t'(q.sense[gi])),
        .pad_out(pin_out[gi]),
        .pad_oe(pin_oe[gi]),
        .hi_drive(pin_hi_drive[gi]),
        .sense_hit(sense_vec[gi])
      );
      // reserved pull code 2 enables neither resistor
      assign pin_pull_up[gi] = q.pull[gi] == PULL_UP; // [RQ12]
      assign pin_pull_dn[gi] = q.pull[gi] == PULL_DOWN; // [RQ12]
      assign pin_in_en[gi] = ~q.in_disc[gi]; // [RQ6]
    end
  endgenerate

  // ******************************************************************
  // detect
  // ******************************************************************
  assign live_detect = |sense_vec; // [RQ2]
  assign latched_port_sense = |q.hit; // [RQ3]
  assign detect = q.det_src ? latched_port_sense : live_detect; // [RQ2] [RQ3]
  assign port_detect = detect;
  // the interrupt event is a rising edge, so a mode switch that raises
  // detect counts as one too
  assign detect_rise = detect & ~q.det_prev;
  assign irq = |(q.irq_stat & q.irq_en);

  // ******************************************************************
  // bus handshakes
  // ******************************************************************
  // a pending response holds off both write halves: one write in flight
  assign s_axi_awready = ~q.aw_got & ~q.bvalid;
  assign s_axi_wready = ~q.w_got & ~q.bvalid;
  assign s_axi_arready = ~q.rvalid;
  assign s_axi_bvalid = q.bvalid;
  assign s_axi_bresp = q.bresp;
  assign s_axi_rvalid = q.rvalid;
  assign s_axi_rresp = q.rresp;
  assign s_axi_rdata = q.rdata;

  // ******************************************************************
  // next state
  // ******************************************************************
  always_comb
  begin
    logic [DATA_W-1:0] m;
    logic [DATA_W-1:0] wd;
    logic [DATA_W-1:0] nw;
    logic [DATA_W-1:0] rd;
    logic [NP-1:0] agree;
    logic [NP-1:0] hit_clr;
    logic [IRQ_W-1:0] irq_clr;
    logic [IRQ_W-1:0] irq_ev;
    logic [PIN_IDX_W-1:0] n;
    logic rd_ok;
    logic wr_ok;
    m = REG_RESET;
    wd = REG_RESET;
    nw = REG_RESET;
    rd = REG_RESET;
    agree = '0;
    hit_clr = '0;
    irq_clr = '0;
    irq_ev = '0;
    n = '0;
    rd_ok = 1'b1;
    wr_ok = 1'b1;
    d = q;

    // three-stage synchroniser; a level counts once stages two and three agree
    d.sync1 = pin_in;
    d.sync2 = q.sync1;
    d.sync3 = q.sync2;
    agree = ~(q.sync2 ^ q.sync3);
    d.level = (q.sync3 & agree) | (q.level & ~agree);

    // write channel capture
    if (s_axi_awvalid && s_axi_awready)
    begin
      d.aw_got = 1'b1;
      d.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      d.w_got = 1'b1;
      d.wdata = s_axi_wdata;
      d.wstrb = s_axi_wstrb;
    end
    if (q.bvalid && s_axi_bready)
    begin
      d.bvalid = 1'b0;
    end

    // write execution, one cycle after both halves are held
    if (q.aw_got && q.w_got && !q.bvalid)
    begin
      m = byte_mask(q.wstrb);
      wd = q.wdata & m;
      if (is_setup(q.awaddr))
      begin
        n = q.awaddr[SETUP_IDX_LSB +: PIN_IDX_W]; // [RQ4]
        // closed byte lanes keep the fields they already hold
        nw = (setup_word(q, n) & ~m) | wd;
        d.dir[n] = nw[CFG_DIR_BIT]; // [RQ5]
        d.in_disc[n] = nw[CFG_INBUF_BIT]; // [RQ6]
        d.pull[n] = nw[CFG_PULL_LSB +: 2]; // [RQ12]
        d.drive[n] = nw[CFG_DRIVE_LSB +: 3]; // [RQ7]
        d.sense[n] = nw[CFG_SENSE_LSB +: 2]; // [RQ10]
      end
      else
      begin
        unique case (q.awaddr)
          OFS_OUT_VALUE: d.out_value = (q.out_value & ~m) | wd;
          OFS_DIRECTION: d.dir = (q.dir & ~m) | wd; // [RQ5]
          OFS_DIR_SET: d.dir = q.dir | wd; // [RQ11]
          OFS_DIR_CLR: d.dir = q.dir & ~wd;
          OFS_SENSE_HIT: hit_clr = wd; // [RQ1]
          OFS_DET_SRC:
          begin
            if (m[DET_SRC_BIT])
            begin
              d.det_src = wd[DET_SRC_BIT]; // [RQ3]
            end
          end
          OFS_IRQ_CLEAR: irq_clr = wd[IRQ_W-1:0];
          OFS_IRQ_ENABLE:
          begin
            d.irq_en = (q.irq_en & ~m[IRQ_W-1:0]) | wd[IRQ_W-1:0];
          end
          // read-only targets ignore the data but still answer okay
          OFS_PIN_LEVEL,
          OFS_IRQ_STATUS: wr_ok = 1'b1;
          default: wr_ok = 1'b0;
        endcase
      end
      d.aw_got = 1'b0;
      d.w_got = 1'b0;
      d.bvalid = 1'b1;
      d.bresp = wr_ok ? RESP_OKAY : RESP_SLVERR;
    end

    // read channel
    if (q.rvalid && s_axi_rready)
    begin
      d.rvalid = 1'b0;
    end
    // read data shows the state before any write landing at this edge
    if (s_axi_arvalid && s_axi_arready)
    begin
      if (is_setup(s_axi_araddr))
      begin
        rd = setup_word(q, s_axi_araddr[SETUP_IDX_LSB +: PIN_IDX_W]); // [RQ4]
      end
      else
      begin
        unique case (s_axi_araddr)
          OFS_OUT_VALUE: rd = q.out_value;
          OFS_PIN_LEVEL: rd = q.level & ~q.in_disc; // [RQ6]
          OFS_DIRECTION,
          OFS_DIR_SET,
          OFS_DIR_CLR: rd = q.dir;
          OFS_SENSE_HIT: rd = q.hit; // [RQ1]
          OFS_DET_SRC: rd[DET_SRC_BIT] = q.det_src;
          OFS_IRQ_STATUS: rd[IRQ_W-1:0] = q.irq_stat;
          OFS_IRQ_CLEAR: rd = REG_RESET;
          OFS_IRQ_ENABLE: rd[IRQ_W-1:0] = q.irq_en;
          // unmapped reads return zero with an error response
          default: rd_ok = 1'b0;
        endcase
      end
      d.rvalid = 1'b1;
      d.rdata = rd;
      d.rresp = rd_ok ? RESP_OKAY : RESP_SLVERR;
    end

    // a pin that senses in the clearing cycle keeps its bit set
    d.hit = (q.hit & ~hit_clr) | sense_vec; // [RQ1]

    // detect rising edge is the interrupt event; set beats clear
    d.det_prev = detect;
    irq_ev[IRQ_DETECT_BIT] = detect_rise;
    d.irq_stat = (q.irq_stat & ~irq_clr) | irq_ev;

    // synchronous reset overrides every update above
    if (!aresetn)
    begin
      d = '0;
      d.hit = REG_RESET; // [RQ1]
      d.in_disc = {NP{CFG_RESET[CFG_INBUF_BIT]}}; // [RQ4] [RQ6]
      d.dir = {NP{CFG_RESET[CFG_DIR_BIT]}}; // [RQ4]
      d.pull = {NP{CFG_RESET[CFG_PULL_LSB +: 2]}}; // [RQ4]
      d.drive = {NP{CFG_RESET[CFG_DRIVE_LSB +: 3]}}; // [RQ4]
      d.sense = {NP{CFG_RESET[CFG_SENSE_LSB +: 2]}}; // [RQ4]
      d.det_src = REG_RESET[DET_SRC_BIT]; // [RQ3]
    end
  end

  // ******************************************************************
  // state register
  // ******************************************************************
  // reset lives in the next-state logic, so this is a plain register
  always_ff @(posedge aclk)
  begin
    q <= d;
  end

endmodule

`default_nettype wire

// ===== bench/gpsl_pins_model.sv
`timescale 1ns/1ps
`default_nettype none

// **********
// far side pins: own drive, outside driver, pulls, else floating
// **********
module gpsl_pins_model
(
  input wire logic aclk,
  input wire logic [gpsl_pkg::PIN_COUNT-1:0] ext_en,
  input wire logic [gpsl_pkg::PIN_COUNT-1:0] ext_lvl,
  input wire logic [gpsl_pkg::PIN_COUNT-1:0] pin_out,
  input wire logic [gpsl_pkg::PIN_COUNT-1:0] pin_oe,
  input wire logic [gpsl_pkg::PIN_COUNT-1:0] pull_up,
  input wire logic [gpsl_pkg::PIN_COUNT-1:0] pull_dn,
  output logic [gpsl_pkg::PIN_COUNT-1:0] pin_in
);
  import gpsl_pkg::*;
  // a floating pin toggles so a stale level is never mistaken for valid
  logic [PIN_COUNT-1:0] float_q = 32'h55555555;
  always_ff @(posedge aclk)
    float_q <= ~float_q;
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_lvl)
    | (~pin_oe & ~ext_en & (pull_up | (~pull_dn & float_q)));
endmodule

`default_nettype wire

// ===== bench/gpsl_port_checker.sv
`timescale 1ns/1ps
`default_nettype none

module gpsl_port_checker
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [gpsl_pkg::DATA_W-1:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [gpsl_pkg::PIN_COUNT-1:0] pin_oe,
  input wire logic [gpsl_pkg::PIN_COUNT-1:0] pin_in_en,
  input wire logic [gpsl_pkg::PIN_COUNT-1:0] pin_pull_up,
  input wire logic [gpsl_pkg::PIN_COUNT-1:0] pin_pull_dn,
  input wire logic port_detect,
  input wire logic irq
);
  import gpsl_pkg::*;
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  sequence s_wtake;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rtake;
    s_axi_arvalid && s_axi_arready;
  endsequence

  a_write_answer: assert property (s_wtake |-> ##[1:3] s_axi_bvalid)
    else $error("write got no response");
  a_read_answer: assert property (s_rtake |-> ##[1:2] s_axi_rvalid)
    else $error("read got no data");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken while busy");
  a_aw_blocked: assert property (s_axi_bvalid |-> !s_axi_awready)
    else $error("write address taken while busy");
  a_pull_excl: assert property ((pin_pull_up & pin_pull_dn) == '0)
    else $error("pull up and down together");
  a_reset_idle: assert property (@(posedge aclk) disable iff (1'b0)
    !aresetn |=> pin_in_en == '0 && pin_oe == '0 && !port_detect && !irq)
    else $error("pins not idle after reset");
endmodule

`default_nettype wire

bind gpsl_port gpsl_port_checker gpsl_port_checker_i (.aclk, .aresetn,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .pin_oe,
  .pin_in_en, .pin_pull_up, .pin_pull_dn, .port_detect, .irq);

// ===== bench/gpsl_port_tb.sv
`timescale 1ns/1ps
`default_nettype none

module gpsl_port_tb;
  import gpsl_pkg::*;
  logic aclk, aresetn;
  logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic [DATA_W-1:0] s_axi_wdata, s_axi_rdata, rdv;
  logic [STRB_W-1:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready, port_detect, irq, eoe, ehi;
  logic [PIN_COUNT-1:0] pin_in, pin_out, pin_oe, pin_hi_drive, pin_in_en;
  logic [PIN_COUNT-1:0] pin_pull_up, pin_pull_dn, ext_en, ext_lvl;
  int n_fail, checks_done, i, d, v;

  gpsl_port gpsl_port_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pin_in, .pin_out, .pin_oe,
    .pin_hi_drive, .pin_in_en, .pin_pull_up, .pin_pull_dn, .port_detect,
    .irq);
  gpsl_pins_model gpsl_pins_model_i (.aclk, .ext_en, .ext_lvl, .pin_out,
    .pin_oe, .pull_up(pin_pull_up), .pull_dn(pin_pull_dn), .pin_in);

  initial
  begin
    aclk = 0;
    forever #4 aclk = ~aclk;
  end

  // **********
  // shared tasks
  // **********
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tmo();
    n_fail++;
    $display("Error at %0t: bus wait ran out", $time);
    wrap_up();
  endtask

  // master holds each channel until its own handshake edge
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] dat);
    logic pa, pw, pb;
    int k;
    pa = 1;
    pw = 1;
    pb = 1;
    s_axi_awaddr <= a;
    s_axi_wdata <= dat;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    for (k = 0; k < 100 && pb; k++)
    begin
      @(posedge aclk);
      if (pa && s_axi_awready)
      begin
        pa = 0;
        s_axi_awvalid <= 0;
      end
      if (pw && s_axi_wready)
      begin
        pw = 0;
        s_axi_wvalid <= 0;
      end
      if (!pa && !pw && s_axi_bvalid)
      begin
        pb = 0;
        rsp = s_axi_bresp;
        s_axi_bready <= 0;
      end
    end
    if (pb)
      tmo();
    @(posedge aclk);
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a);
    logic pa, pr;
    int k;
    pa = 1;
    pr = 1;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    for (k = 0; k < 100 && pr; k++)
    begin
      @(posedge aclk);
      if (pa && s_axi_arready)
      begin
        pa = 0;
        s_axi_arvalid <= 0;
      end
      if (!pa && s_axi_rvalid)
      begin
        pr = 0;
        rdv = s_axi_rdata;
        rsp = s_axi_rresp;
        s_axi_rready <= 0;
      end
    end
    if (pr)
      tmo();
    @(posedge aclk);
  endtask

  function automatic logic [ADDR_W-1:0] cfg(input int n);
    return OFS_PIN_SETUP + ADDR_W'(n * 4);
  endfunction

  // **********
  // tests
  // **********
  initial
  begin
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} <= '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= '0;
    {s_axi_arvalid, s_axi_rready} <= '0;
    s_axi_wstrb <= 4'hF;
    ext_en <= 32'h00000200;
    ext_lvl <= '0;
    n_fail = 0;
    checks_done = 0;
    aresetn <= 0;
    repeat (2) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
    chk(pin_in_en, 32'h0);
    for (i = 0; i < PIN_COUNT; i++)
    begin
      rd(cfg(i));
      chk(rdv, CFG_RESET);
    end
    rd(OFS_SENSE_HIT);
    chk(rdv, REG_RESET);
    rd(OFS_DET_SRC);
    chk(rdv, REG_RESET);
    $display("test reset values done");
    wr(cfg(5), 32'hFFFFFFFF);
    chk(rsp, RESP_OKAY);
    rd(cfg(5));
    chk(rdv, 32'h0003070F);
    rd(OFS_DIRECTION);
    chk(rdv, 32'h00000020);
    wr(cfg(5), CFG_RESET);
    wr(OFS_DIR_SET, 32'h00000080);
    wr(OFS_DIR_SET, 32'h00000000);
    rd(OFS_DIRECTION);
    chk(rdv, 32'h00000080);
    rd(cfg(7));
    chk(rdv, 32'h00000003);
    wr(OFS_DIR_CLR, 32'h00000080);
    rd(cfg(7));
    chk(rdv, CFG_RESET);
    $display("test layout and direction done");
    for (d = 0; d < 8; d++)
      for (v = 0; v < 2; v++)
      begin
        wr(OFS_OUT_VALUE, 32'(v) << 3);
        wr(cfg(3), (32'(d) << CFG_DRIVE_LSB) | 32'h3);
        eoe = !((d == 4 || d == 5) && v == 0) && !(d >= 6 && v == 1);
        ehi = v ? (d == 2 || d == 3 || d == 5) : (d == 1 || d == 3 || d == 7);
        chk({pin_oe[3], pin_out[3]}, {eoe, v[0]});
        chk(pin_hi_drive[3] & eoe, ehi & eoe);
      end
    for (d = 0; d < 4; d++)
    begin
      wr(cfg(3), (32'(d) << CFG_PULL_LSB) | 32'h2);
      chk({pin_pull_up[3], pin_pull_dn[3]}, {d == 3, d == 1});
    end
    $display("test drive and pull done");
    wr(OFS_IRQ_ENABLE, 32'h1);
    wr(cfg(9), 32'h00020000);
    chk(pin_in_en[9], 1'b1);
    repeat (8) @(posedge aclk);
    chk(port_detect, 1'b0);
    ext_lvl[9] <= 1;
    repeat (8) @(posedge aclk);
    chk({port_detect, irq}, 2'b11);
    rd(OFS_PIN_LEVEL);
    chk(rdv, 32'h00000200);
    rd(OFS_SENSE_HIT);
    chk(rdv, 32'h00000200);
    ext_lvl[9] <= 0;
    repeat (8) @(posedge aclk);
    chk(port_detect, 1'b0);
    wr(OFS_DET_SRC, 32'h1);
    chk(port_detect, 1'b1);
    wr(OFS_IRQ_ENABLE, 32'h0);
    chk(irq, 1'b0);
    wr(OFS_IRQ_CLEAR, 32'h1);
    rd(OFS_IRQ_STATUS);
    chk(rdv, 32'h0);
    wr(OFS_SENSE_HIT, 32'h00000100);
    rd(OFS_SENSE_HIT);
    chk(rdv, 32'h00000200);
    wr(OFS_SENSE_HIT, 32'h00000200);
    rd(OFS_SENSE_HIT);
    chk({rdv[9], port_detect}, 2'b00);
    wr(OFS_DET_SRC, 32'h0);
    wr(cfg(9), 32'h00030000);
    repeat (8) @(posedge aclk);
    chk(port_detect, 1'b1);
    wr(cfg(9), 32'h00030002);
    repeat (8) @(posedge aclk);
    chk(port_detect, 1'b0);
    wr(cfg(9), 32'h00010000);
    repeat (8) @(posedge aclk);
    chk(port_detect, 1'b0);
    wr(cfg(9), 32'h00000000);
    repeat (8) @(posedge aclk);
    chk(port_detect, 1'b0);
    $display("test sense and detect done");
    rd(12'h400);
    chk(rsp, RESP_SLVERR);
    chk(rdv, 32'h0);
    $display("test unmapped done");
    wrap_up();
  end
endmodule

`default_nettype wire
